/* File: design/cida_pkg.sv */
// shared constants and carrier types of the configuration index/data access unit
package cida_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	localparam int STRAP_W = 5;
	localparam int LOC_W = 2;
	localparam int IDX_W = 4;
	// register indices
	localparam logic [IDX_W-1:0] IDX_FUNC_ENABLE = 4'h0;
	localparam logic [IDX_W-1:0] IDX_FUNC_ADDRESS = 4'h1;
	localparam logic [IDX_W-1:0] IDX_POWER_TEST = 4'h2;
	localparam int STRAPPED_REGS = 3;
	// pointer layout: bits 4-6 reserved, read zero
	localparam logic [DATA_W-1:0] POINTER_KEEP_MASK = 8'h8f;
	localparam logic [DATA_W-1:0] POINTER_RESET = 8'h00;
	localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
	// pair locations, indexed by the location straps
	localparam logic [3:0][ADDR_W-1:0] PAIR_INDEX_ADDR = {16'h002e, 16'h015c, 16'h026e, 16'h0398};
	localparam logic [ADDR_W-1:0] PAIR_DATA_OFFSET = 16'h0001;
	// function enable, function address and power/test bit positions
	localparam int FE_PARALLEL = 0;
	localparam int FE_SERIAL1 = 1;
	localparam int FE_SERIAL2 = 2;
	localparam int FE_FLOPPY = 3;
	localparam int FE_DISK = 6;
	localparam int FE_DISK_SECONDARY = 7;
	localparam int FA_PAR_LSB = 0;
	localparam int FA_SER1_LSB = 2;
	localparam int FA_SER2_LSB = 4;
	localparam int PT_XTAL_STOP = 1;
	// serial windows: serial_addr_first .. serial_addr_fourth
	localparam logic [3:0][ADDR_W-1:0] SERIAL_BASE = {16'h02e8, 16'h03e8, 16'h02f8, 16'h03f8};
	localparam int SERIAL_SPAN_LSB = 3;
	// disk drive windows
	localparam logic [ADDR_W-1:0] DISK_MAIN_BASE = 16'h01f0;
	localparam logic [ADDR_W-1:0] DISK_ALT_BASE = 16'h0170;
	localparam int DISK_SPAN_LSB = 3;
	localparam logic [ADDR_W-1:0] DISK_MAIN_CTL = 16'h03f6;
	localparam logic [ADDR_W-1:0] DISK_ALT_CTL = 16'h0376;
	localparam int DISK_CTL_SPAN_LSB = 1;
	// parallel windows
	localparam logic [ADDR_W-1:0] PAR_SECOND_BASE = 16'h0378;
	localparam logic [ADDR_W-1:0] PAR_FIRST_LO = 16'h03bc;
	localparam logic [ADDR_W-1:0] PAR_FIRST_HI = 16'h03be;
	localparam logic [ADDR_W-1:0] PAR_THIRD_BASE = 16'h0278;
	localparam int PAR_SPAN_LSB = 3;
	localparam logic [1:0] PAR_SEL_SECOND = 2'h0;
	localparam logic [1:0] PAR_SEL_FIRST = 2'h1;
	localparam logic [1:0] PAR_SEL_THIRD = 2'h2;
	// strap defaults: {function_enable, function_address}, entry 31 first
	localparam logic [31:0][15:0] STRAP_DEFAULTS = {
		16'h0010, 16'h0810, 16'hc738, 16'h4724, 16'h4739, 16'hc711, 16'h4711, 16'h4710,
		16'h0724, 16'h0739, 16'h0711, 16'h0710, 16'hc900, 16'hc901, 16'h4901, 16'h4900,
		16'h0f24, 16'h0f39, 16'h0f11, 16'h0f10, 16'hcb08, 16'h4b08, 16'h4b09, 16'hcb01,
		16'h4b01, 16'h4b00, 16'hcf38, 16'h4f24, 16'h4f39, 16'hcf11, 16'h4f11, 16'h4f10};
	localparam logic [STRAP_W-1:0] STRAP_NONE = 5'h1f;
	localparam logic [DATA_W-1:0] PT_DEFAULT_ACTIVE = 8'h00;
	localparam logic [DATA_W-1:0] PT_DEFAULT_NONE = 8'h02;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic iow;
		logic ior;
	} cida_bus_req_type;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic rvalid;
	} cida_bus_rsp_type;

	typedef struct packed {
		logic serial1;
		logic serial2;
		logic disk;
		logic parallel;
	} cida_sel_type;

	typedef struct packed {
		logic parallel;
		logic serial1;
		logic serial2;
		logic floppy;
		logic disk;
	} cida_func_clk_type;
endpackage

/* File: design/cida_config_access.sv */
// index/data configuration register access unit with strap defaults and address decode
`timescale 1ns/1ns
// Summary of operation
// - straps pick one of 32 defaults at reset
// - other registers get no strap defaults
// - data read returns register selected by pointer
// - pointer read returns last written value
// - first pointer read after reset gives identity
// - second pointer read after reset gives zero
// - pointer write cancels the identity read
// - pointer bits 4-6 read zero, except on the identity read
// - register updates on second back-to-back data write
// - software may overwrite strap defaults later
// - function sets load power/test zero default
// - all straps high: nothing enabled, crystal stops
// - all straps low: full set at primary
// - disk secondary picks higher enable value
// - serial selections decode eight-byte windows
// - disk selections decode block plus control pair
// - location straps place the index/data pair
// - disabled functions get clocks gated off
module cida_config_access #(
	parameter int NUM_REGS = 15,
	parameter logic [7:0] ID_BYTE = 8'h5a // arbitrary identity value
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire cida_pkg::cida_bus_req_type i_bus,
	output cida_pkg::cida_bus_rsp_type o_bus,
	input wire logic [cida_pkg::STRAP_W-1:0] i_default_select_straps,
	input wire logic [cida_pkg::LOC_W-1:0] i_pair_location_straps,
	input wire logic i_power_down_input_n,
	output cida_pkg::cida_sel_type o_sel,
	output cida_pkg::cida_func_clk_type o_func_clk_en,
	output logic o_clocks_stop,
	output logic o_xtal_stop
);
	localparam int MAX_REGS = 16;

	if (NUM_REGS < cida_pkg::STRAPPED_REGS || NUM_REGS > MAX_REGS) begin : g_bad_regs
		$error("NUM_REGS must lie between 3 and 16");
	end

	typedef struct packed {
		logic [cida_pkg::STRAP_W-1:0] cfg_s1;
		logic [cida_pkg::STRAP_W-1:0] cfg_s2;
		logic [cida_pkg::LOC_W-1:0] loc_s1;
		logic [cida_pkg::LOC_W-1:0] loc_s2;
		logic power_down_input_s1;
		logic power_down_input_s2;
		logic [cida_pkg::LOC_W-1:0] loc;
		logic [NUM_REGS-1:0][cida_pkg::DATA_W-1:0] regs;
		logic [cida_pkg::DATA_W-1:0] pointer;
		logic id_pending;
		logic first_write;
		logic [cida_pkg::DATA_W-1:0] rdata;
		logic rvalid;
	} cida_state_type;

	cida_state_type state;
	cida_state_type next_state;

	logic [cida_pkg::ADDR_W-1:0] index_addr;
	logic [cida_pkg::ADDR_W-1:0] data_addr;
	logic hit_index;
	logic hit_data;
	logic pointer_valid;
	logic [cida_pkg::IDX_W-1:0] sel_idx;
	logic [15:0] strap_pair;
	logic [cida_pkg::DATA_W-1:0] fe;
	logic [cida_pkg::DATA_W-1:0] fa;
	logic [cida_pkg::DATA_W-1:0] pt;

	function automatic logic in_window(input logic [cida_pkg::ADDR_W-1:0] a,
		input logic [cida_pkg::ADDR_W-1:0] base, input int span_lsb);
		logic [cida_pkg::ADDR_W-1:0] mask;
		mask = '1;
		mask = mask << span_lsb;
		return (a & mask) == (base & mask);
	endfunction

	function automatic logic serial_hit(input logic [cida_pkg::ADDR_W-1:0] a, input logic [1:0] code);
		return in_window(a, cida_pkg::SERIAL_BASE[code], cida_pkg::SERIAL_SPAN_LSB);
	endfunction

	// pair address comes from the straps caught at reset, not the live pins
	assign index_addr = cida_pkg::PAIR_INDEX_ADDR[state.loc];
	assign data_addr = index_addr + cida_pkg::PAIR_DATA_OFFSET;
	assign hit_index = i_bus.addr == index_addr;
	assign hit_data = i_bus.addr == data_addr;
	assign sel_idx = state.pointer[cida_pkg::IDX_W-1:0];
	// bit 7 set points outside the map as well
	assign pointer_valid = (state.pointer[cida_pkg::DATA_W-1] == 1'b0) && (int'(sel_idx) < NUM_REGS);
	assign strap_pair = cida_pkg::STRAP_DEFAULTS[state.cfg_s2];
	assign fe = state.regs[cida_pkg::IDX_FUNC_ENABLE];
	assign fa = state.regs[cida_pkg::IDX_FUNC_ADDRESS];
	assign pt = state.regs[cida_pkg::IDX_POWER_TEST];

	always_comb begin
		next_state = state;
		// synchroniser chains run through reset so the straps are settled at release
		next_state.cfg_s1 = i_default_select_straps;
		next_state.cfg_s2 = state.cfg_s1;
		next_state.loc_s1 = i_pair_location_straps;
		next_state.loc_s2 = state.loc_s1;
		next_state.power_down_input_s1 = ~i_power_down_input_n;
		next_state.power_down_input_s2 = state.power_down_input_s1;
		next_state.rvalid = 1'b0;
		if (!i_reset_n) begin
			next_state.loc = state.loc_s2;
			for (int i = 0; i < NUM_REGS; i++) begin
				next_state.regs[i] = cida_pkg::REG_RESET;
			end
			// high byte is the enable default, already resolved for disk location
			next_state.regs[cida_pkg::IDX_FUNC_ENABLE] = strap_pair[15:8];
			next_state.regs[cida_pkg::IDX_FUNC_ADDRESS] = strap_pair[7:0];
			if (state.cfg_s2 == cida_pkg::STRAP_NONE) begin
				next_state.regs[cida_pkg::IDX_POWER_TEST] = cida_pkg::PT_DEFAULT_NONE;
			end else begin
				next_state.regs[cida_pkg::IDX_POWER_TEST] = cida_pkg::PT_DEFAULT_ACTIVE;
			end
			next_state.pointer = cida_pkg::POINTER_RESET;
			next_state.id_pending = 1'b1;
			next_state.first_write = 1'b0;
			next_state.rdata = cida_pkg::UNMAPPED_READ;
		end else if (i_bus.iow && hit_index) begin
			next_state.pointer = i_bus.wdata & cida_pkg::POINTER_KEEP_MASK;
			next_state.id_pending = 1'b0;
			next_state.first_write = 1'b0;
		end else if (i_bus.iow && hit_data) begin
			if (state.first_write) begin
				if (pointer_valid) begin
					next_state.regs[sel_idx] = i_bus.wdata;
				end
				next_state.first_write = 1'b0;
			end else begin
				next_state.first_write = 1'b1;
			end
		end else if (i_bus.ior && hit_index) begin
			next_state.rvalid = 1'b1;
			next_state.first_write = 1'b0;
			if (state.id_pending) begin
				next_state.rdata = ID_BYTE;
				next_state.id_pending = 1'b0;
			end else begin
				next_state.rdata = state.pointer;
			end
		end else if (i_bus.ior && hit_data) begin
			next_state.rvalid = 1'b1;
			next_state.first_write = 1'b0;
			// reads never touch the stored values
			if (pointer_valid) begin
				next_state.rdata = state.regs[sel_idx];
			end else begin
				next_state.rdata = cida_pkg::UNMAPPED_READ;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		state <= next_state;
	end

	assign o_bus.rdata = state.rdata;
	assign o_bus.rvalid = state.rvalid;

	// peripheral selects follow the live register contents
	always_comb begin
		o_sel.serial1 = fe[cida_pkg::FE_SERIAL1] && serial_hit(i_bus.addr, fa[cida_pkg::FA_SER1_LSB +: 2]);
		o_sel.serial2 = fe[cida_pkg::FE_SERIAL2] && serial_hit(i_bus.addr, fa[cida_pkg::FA_SER2_LSB +: 2]);
		if (fe[cida_pkg::FE_DISK_SECONDARY]) begin
			o_sel.disk = in_window(i_bus.addr, cida_pkg::DISK_ALT_BASE, cida_pkg::DISK_SPAN_LSB)
				|| in_window(i_bus.addr, cida_pkg::DISK_ALT_CTL, cida_pkg::DISK_CTL_SPAN_LSB);
		end else begin
			o_sel.disk = in_window(i_bus.addr, cida_pkg::DISK_MAIN_BASE, cida_pkg::DISK_SPAN_LSB)
				|| in_window(i_bus.addr, cida_pkg::DISK_MAIN_CTL, cida_pkg::DISK_CTL_SPAN_LSB);
		end
		o_sel.disk = o_sel.disk && fe[cida_pkg::FE_DISK];
		unique case (fa[cida_pkg::FA_PAR_LSB +: 2])
			cida_pkg::PAR_SEL_SECOND: begin
				o_sel.parallel = in_window(i_bus.addr, cida_pkg::PAR_SECOND_BASE, cida_pkg::PAR_SPAN_LSB);
			end
			cida_pkg::PAR_SEL_FIRST: begin
				o_sel.parallel = (i_bus.addr >= cida_pkg::PAR_FIRST_LO) && (i_bus.addr <= cida_pkg::PAR_FIRST_HI);
			end
			cida_pkg::PAR_SEL_THIRD: begin
				o_sel.parallel = in_window(i_bus.addr, cida_pkg::PAR_THIRD_BASE, cida_pkg::PAR_SPAN_LSB);
			end
			default: begin
				// reserved code decodes nothing
				o_sel.parallel = 1'b0;
			end
		endcase
		o_sel.parallel = o_sel.parallel && fe[cida_pkg::FE_PARALLEL];
	end

	// power-down gating: functions keep their state, only clocks stop
	assign o_clocks_stop = state.power_down_input_s2;
	assign o_xtal_stop = state.power_down_input_s2 && pt[cida_pkg::PT_XTAL_STOP];
	assign o_func_clk_en.parallel = fe[cida_pkg::FE_PARALLEL] && !state.power_down_input_s2;
	assign o_func_clk_en.serial1 = fe[cida_pkg::FE_SERIAL1] && !state.power_down_input_s2;
	assign o_func_clk_en.serial2 = fe[cida_pkg::FE_SERIAL2] && !state.power_down_input_s2;
	assign o_func_clk_en.floppy = fe[cida_pkg::FE_FLOPPY] && !state.power_down_input_s2;
	assign o_func_clk_en.disk = fe[cida_pkg::FE_DISK] && !state.power_down_input_s2;
endmodule

/* File: testbench/cida_config_access_assertions.sv */
// port checks of the configuration access unit
`timescale 1ns/1ns
module cida_config_access_assertions (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire cida_pkg::cida_bus_req_type i_bus,
	input wire cida_pkg::cida_bus_rsp_type o_bus,
	input wire logic [cida_pkg::LOC_W-1:0] i_pair_location_straps,
	input wire logic i_power_down_input_n,
	input wire cida_pkg::cida_sel_type o_sel,
	input wire cida_pkg::cida_func_clk_type o_func_clk_en,
	input wire logic o_clocks_stop,
	input wire logic o_xtal_stop
);
	logic [15:0] base;
	logic hit_idx;
	logic hit;
	logic pointer_seen;
	// straps held still after reset, so raw straps match the captured location
	assign base = cida_pkg::PAIR_INDEX_ADDR[i_pair_location_straps];
	assign hit_idx = i_bus.addr == base;
	assign hit = hit_idx || i_bus.addr == base + 16'h0001;
	always_ff @(posedge i_clk) begin
		if (!i_reset_n)
			pointer_seen <= 1'b0;
		else if (hit_idx && (i_bus.iow || i_bus.ior))
			pointer_seen <= 1'b1;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_pair_read;
		i_bus.ior && !i_bus.iow && hit;
	endsequence
	sequence s_late_pointer_read;
		s_pair_read ##0 (hit_idx && pointer_seen);
	endsequence
	chk_read_answer: assert property (s_pair_read |=> o_bus.rvalid)
		else $error("read got no answer");
	chk_answer_cause: assert property (o_bus.rvalid |-> $past(i_bus.ior && !i_bus.iow && hit))
		else $error("answer without read");
	chk_rsvd_zero: assert property (s_late_pointer_read |=> o_bus.rdata[6:4] == 3'h0)
		else $error("reserved pointer bits set");
	chk_rdata_hold: assert property (!o_bus.rvalid |-> $stable(o_bus.rdata))
		else $error("read data moved");
	chk_stop_lat: assert property (!i_power_down_input_n [*4] |-> o_clocks_stop)
		else $error("clocks not stopped");
	chk_run_lat: assert property (i_power_down_input_n [*4] |-> !o_clocks_stop)
		else $error("clocks stopped while running");
	chk_xtal_gate: assert property (o_xtal_stop |-> o_clocks_stop)
		else $error("crystal stop alone");
	chk_clk_gated: assert property (o_clocks_stop |-> o_func_clk_en == '0)
		else $error("function clock left on");
	chk_serial_win: assert property (o_sel.serial1 || o_sel.serial2 |->
		i_bus.addr[15:3] inside {13'h007f, 13'h005f, 13'h007d, 13'h005d})
		else $error("serial select outside window");
	chk_disk_win: assert property (o_sel.disk |-> i_bus.addr[15:3] inside {13'h003e, 13'h002e} ||
		i_bus.addr[15:1] inside {15'h01fb, 15'h01bb})
		else $error("disk select outside window");
endmodule

/* File: testbench/cida_host_model.sv */
// host model: one-cycle io strobes at the falling edge
`timescale 1ns/1ns
module cida_host_model (
	input wire logic i_clk,
	input wire cida_pkg::cida_bus_rsp_type i_rsp,
	output cida_pkg::cida_bus_req_type o_req
);
	initial o_req = '0;
	// released lines show the inverse, so a stale address never looks valid
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_req = '{addr: a, wdata: d, iow: 1'b1, ior: 1'b0};
		@(negedge i_clk);
		o_req = '{addr: ~a, wdata: ~d, iow: 1'b0, ior: 1'b0};
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_req = '{addr: a, wdata: 8'h00, iow: 1'b0, ior: 1'b1};
		@(negedge i_clk);
		d = (i_rsp.rvalid === 1'b1) ? i_rsp.rdata : 8'hxx;
		o_req = '{addr: ~a, wdata: 8'hff, iow: 1'b0, ior: 1'b0};
	endtask
	task automatic put(input logic [15:0] a);
		@(negedge i_clk);
		o_req = '{addr: a, wdata: 8'h00, iow: 1'b0, ior: 1'b0};
		@(negedge i_clk);
	endtask
endmodule

/* File: testbench/test_cida_config_access.sv */
// self-checking bench for the configuration access unit
`timescale 1ns/1ns
module test_cida_config_access;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [4:0] straps = 5'h00;
	logic [1:0] loc = 2'h0;
	logic power_down_input_n = 1'b1;
	cida_pkg::cida_bus_req_type req;
	cida_pkg::cida_bus_rsp_type rsp;
	cida_pkg::cida_sel_type sel;
	cida_pkg::cida_func_clk_type clk_en;
	logic clocks_stop;
	logic xtal_stop;
	logic [7:0] d;
	logic [15:0] sel_addr [7] = '{16'h03ff, 16'h02f8, 16'h03e8, 16'h01f7, 16'h03f7, 16'h0376, 16'h037f};
	logic [3:0] sel_exp [7] = '{4'h8, 4'h4, 4'h0, 4'h2, 4'h2, 4'h0, 4'h1};
	int mismatches = 0;
	int n_compared = 0;
	always #5 i_clk = ~i_clk;
	// identity value is arbitrary
	cida_config_access #(.NUM_REGS(15), .ID_BYTE(8'h3c)) dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_bus(req), .o_bus(rsp), .i_default_select_straps(straps), .i_pair_location_straps(loc),
		.i_power_down_input_n(power_down_input_n), .o_sel(sel), .o_func_clk_en(clk_en), .o_clocks_stop(clocks_stop),
		.o_xtal_stop(xtal_stop));
	cida_host_model host_u (.i_clk(i_clk), .i_rsp(rsp), .o_req(req));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rc(input logic [15:0] a, input logic [7:0] exp);
		host_u.rd(a, d);
		chk(d, exp);
	endtask
	// three edges: two sync stages plus the capture
	task automatic do_reset(input logic [4:0] s, input logic [1:0] l);
		@(negedge i_clk);
		straps = s;
		loc = l;
		i_reset_n = 1'b0;
		repeat (3) @(negedge i_clk);
		i_reset_n = 1'b1;
	endtask
	task automatic pulse_power_down_input(input logic xtal);
		power_down_input_n = 1'b0;
		repeat (5) @(negedge i_clk);
		chk(clocks_stop, 1'b1);
		chk(xtal_stop, xtal);
		power_down_input_n = 1'b1;
		repeat (5) @(negedge i_clk);
	endtask
	task automatic t_defaults;
		do_reset(5'h00, 2'h0);
		rc(16'h0398, 8'h3c);
		rc(16'h0398, 8'h00);
		rc(16'h0399, 8'h4f);
		chk(clk_en, 5'h1f);
		host_u.wr(16'h0398, 8'h01);
		rc(16'h0399, 8'h10);
		host_u.wr(16'h0398, 8'h02);
		rc(16'h0399, 8'h00);
		host_u.wr(16'h0398, 8'h03);
		rc(16'h0399, 8'h00);
		pulse_power_down_input(1'b0);
	endtask
	task automatic t_decode;
		for (int i = 0; i < 7; i++) begin
			host_u.put(sel_addr[i]);
			chk(sel, sel_exp[i]);
		end
	endtask
	task automatic t_double;
		host_u.wr(16'h0398, 8'hfe);
		rc(16'h0398, 8'h8e);
		host_u.wr(16'h0398, 8'h70);
		rc(16'h0398, 8'h00);
		host_u.wr(16'h0399, 8'h00);
		rc(16'h0398, 8'h00);
		host_u.wr(16'h0399, 8'h00);
		rc(16'h0399, 8'h4f);
		host_u.wr(16'h0399, 8'h00);
		host_u.wr(16'h0399, 8'h00);
		rc(16'h0399, 8'h00);
		chk(clk_en, 5'h00);
	endtask
	task automatic t_others;
		do_reset(5'h1f, 2'h3);
		host_u.wr(16'h002e, 8'h02);
		rc(16'h002e, 8'h02);
		rc(16'h002f, 8'h02);
		host_u.wr(16'h002e, 8'h00);
		rc(16'h002f, 8'h00);
		pulse_power_down_input(1'b1);
		do_reset(5'h02, 2'h1);
		rc(16'h026f, 8'hcf);
		host_u.wr(16'h026e, 8'h01);
		rc(16'h026f, 8'h11);
		host_u.put(16'h0177);
		chk(sel, 4'h2);
		host_u.put(16'h01f0);
		chk(sel, 4'h0);
		do_reset(5'h1e, 2'h2);
		rc(16'h015d, 8'h08);
	endtask
	task automatic end_of_test;
		if (mismatches == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		t_defaults;
		t_decode;
		t_double;
		t_others;
		end_of_test;
	end
	// about 110 cycles expected; hang limit well above
	initial begin
		#100000;
		mismatches++;
		end_of_test;
	end
endmodule
bind cida_config_access cida_config_access_assertions chk_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_bus(i_bus),
	.o_bus(o_bus), .i_pair_location_straps(i_pair_location_straps), .i_power_down_input_n(i_power_down_input_n),
	.o_sel(o_sel), .o_func_clk_en(o_func_clk_en), .o_clocks_stop(o_clocks_stop), .o_xtal_stop(o_xtal_stop));
